// ### scl_pkg.sv
/*
  Shared constants and types of the strap configuration latch: register
  offsets, strap level codes, configuration field encodings and reset values.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package scl_pkg;

  // Strap level codes: 0..3 are pull-downs 0 ohm..100 kohm, 4..7 pull-ups 100 kohm..0 ohm.
  localparam int          STRAP_N        = 5;
  localparam int          CODE_W         = 3;
  localparam logic [2:0]  CODE_SW_MODE   = 3'h7;
  localparam logic [2:0]  CODE_PULLUP    = 3'h4;
  localparam int          IDX_ROLE       = 0;
  localparam int          IDX_FMT        = 1;
  localparam int          IDX_SLOT       = 2;
  localparam int          IDX_CLK        = 3;
  localparam int          IDX_FILT       = 4;

  // Wishbone register map, byte addresses of 32-bit words.
  localparam int          ADR_W          = 8;
  localparam logic [7:0]  ADR_STATUS     = 8'h00;
  localparam logic [7:0]  ADR_ACTIVE     = 8'h04;
  localparam logic [7:0]  ADR_SW_CFG     = 8'h08;
  localparam logic [7:0]  ADR_STRAPS     = 8'h0C;

  // Status register bit positions.
  localparam int          ST_IN_RESET    = 0;
  localparam int          ST_READY       = 1;
  localparam int          ST_SW_MODE     = 2;
  localparam int          ST_CFG_ERR     = 3;
  localparam int          ST_AUTODETECT  = 4;

  // Base rates of the two families and reference ratios.
  localparam int          BASE_48K_HZ    = 48000;
  localparam int          BASE_44K1_HZ   = 44100;
  localparam logic [9:0]  RATIO_BCLK     = 10'h040;
  localparam logic [9:0]  RATIO_MCLK256  = 10'h100;
  localparam logic [9:0]  RATIO_MCLK512  = 10'h200;

  // The only rates that autodetect will lock to, in Hz.
  localparam int          AUTOD_RATES_HZ [7] = '{32000, 44100, 48000, 88200, 96000, 176400, 192000};

  typedef enum logic [1:0] {SCL_R48, SCL_R96, SCL_R192, SCL_RAUTO} scl_rate_t;
  typedef enum logic [2:0] {SCL_I2S, SCL_LJ, SCL_TDM_MIN, SCL_TDM_MAX, SCL_FMT_UNDEF} scl_fmt_t;
  typedef enum logic [1:0] {SCL_BCLK64, SCL_MCLK512_BYP, SCL_MCLK256_PLL, SCL_MCLK512_PLL} scl_clk_t;
  typedef enum logic [1:0] {SCL_ST_RESET, SCL_ST_LATCH, SCL_ST_RUN} scl_state_t;

  typedef struct packed {
    logic      role_primary;
    scl_rate_t rate;
    scl_fmt_t  fmt;
    logic      launch_full;
    logic [2:0] slot_pair;
    scl_clk_t  clk_ref;
    logic      order_rev;
    logic      hpf_bypass;
    logic      linear;
    logic      fast;
  } scl_cfg_t;

  localparam logic [15:0] SW_CFG_RST     = 16'h0020;

  // Flags combinations that the clocking cannot support, and any undefined format.
  function automatic logic scl_cfg_err(input scl_cfg_t c);
    logic bclk;
    bclk = (c.clk_ref == SCL_BCLK64);
    return (bclk && (c.role_primary || c.rate == SCL_RAUTO || c.fmt == SCL_TDM_MAX))
           || (c.fmt == SCL_FMT_UNDEF);
  endfunction

endpackage

// ### scl_dec_if.sv
/*
  Carrier between the latch core and the strap decoder: latched strap codes
  one way, decoded settings the other. Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface scl_dec_if;
  import scl_pkg::*;

  logic [STRAP_N-1:0][CODE_W-1:0] strap;
  scl_cfg_t                       cfg;
  logic                           sw_mode;
  logic                           err;

  modport dec  (input strap, output cfg, output sw_mode, output err);
  modport core (output strap, input cfg, input sw_mode, input err);
endinterface
`default_nettype wire

// ### scl_strap_decode.sv
/*
  Combinational decoder from five 3-bit strap level codes to configuration
  settings. Assumes the codes are already latched and stable.
*/
`timescale 1ns/1ps
`default_nettype none
module scl_strap_decode
  import scl_pkg::*;
(
  scl_dec_if.dec dif
);

  // Each strap is decoded separately except the slot pair, which depends on the format; mirrored tables share one folded index.
  always_comb begin
    logic [2:0] c0;
    logic [2:0] c1;
    logic [1:0] m4;
    logic [1:0] m5;
    scl_cfg_t   c;
    c0 = dif.strap[IDX_ROLE];
    c1 = dif.strap[IDX_FMT];
    m4 = dif.strap[IDX_CLK][2] ? ~dif.strap[IDX_CLK][1:0] : dif.strap[IDX_CLK][1:0];
    m5 = dif.strap[IDX_FILT][2] ? ~dif.strap[IDX_FILT][1:0] : dif.strap[IDX_FILT][1:0];
    c = scl_cfg_t'(SW_CFG_RST);
    dif.sw_mode = (c0 == CODE_SW_MODE);
    c.role_primary = (c0 >= CODE_PULLUP) && !dif.sw_mode;
    case (c0)
      3'h6, 3'h1: c.rate = SCL_R48;
      3'h5, 3'h2: c.rate = SCL_R96;
      3'h4, 3'h3: c.rate = SCL_R192;
      3'h0:       c.rate = SCL_RAUTO;
      default:    c.rate = SCL_R48;
    endcase
    c.launch_full = 1'b0;
    case (c1)
      3'h7: c.fmt = SCL_TDM_MIN;
      3'h6: c.fmt = SCL_TDM_MAX;
      3'h5: begin
        c.fmt = SCL_TDM_MAX;
        c.launch_full = 1'b1;
      end
      3'h1: c.fmt = SCL_LJ;
      3'h0: c.fmt = SCL_I2S;
      default: c.fmt = SCL_FMT_UNDEF;
    endcase
    // Slot pair n carries slots 2n and 2n+1; only meaningful for maximum-slot TDM.
    c.slot_pair = (c.fmt == SCL_TDM_MAX) ? dif.strap[IDX_SLOT] : 3'h0;
    c.clk_ref = scl_clk_t'(m4);
    c.order_rev = !dif.strap[IDX_CLK][2];
    c.hpf_bypass = dif.strap[IDX_FILT][2];
    c.linear = m5[1];
    c.fast = m5[0];
    dif.cfg = c;
    dif.err = !dif.sw_mode && scl_cfg_err(c);
  end

endmodule
`default_nettype wire

// ### scl_strap_latch.sv
/*
  Strap configuration latch: qualifies device reset, samples the five strap
  level codes when reset is released, holds the decoded settings until the
  next reset, and hands over to a Wishbone-written register in software mode.
  Assumes all inputs are synchronous to clk_i and a classic Wishbone master.
*/
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
module scl_strap_latch
  import scl_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic              reset_n_i,
  input  wire logic              avdd_low_i,
  input  wire logic              dvdd_low_i,
  input  wire logic [CODE_W-1:0] role_rate_strap_i,
  input  wire logic [CODE_W-1:0] format_strap_i,
  input  wire logic [CODE_W-1:0] slot_pair_strap_i,
  input  wire logic [CODE_W-1:0] clock_order_strap_i,
  input  wire logic [CODE_W-1:0] filter_strap_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_we_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic [DATA_W-1:0]      wb_dat_o,
  output logic                   wb_ack_o,
  output scl_cfg_t               cfg_o,
  output logic                   device_in_reset_o,
  output logic                   config_ready_o,
  output logic                   sw_mode_o,
  output logic                   cfg_err_o,
  output logic                   autodetect_en_o,
  output logic [9:0]             ref_ratio_o,
  output logic                   gain_pins_en_o,
  output logic [CODE_W-1:0]      i2c_addr_sel_o
);

  typedef struct packed {
    scl_state_t                     fsm;
    logic [STRAP_N-1:0][CODE_W-1:0] strap;
    scl_cfg_t                       act;
    scl_cfg_t                       sw;
    logic                           sw_mode;
    logic                           err;
    logic                           ready;
    logic                           in_rst;
    logic                           autod;
    logic [9:0]                     ratio;
    logic                           gain_en;
    logic [CODE_W-1:0]              i2c_sel;
    logic                           ack;
    logic [DATA_W-1:0]              rdat;
  } scl_st_t;

  scl_st_t                        st_r;
  scl_st_t                        st_nxt;
  logic [STRAP_N-1:0][CODE_W-1:0] strap_in;
  logic [DATA_W-1:0]              sel_mask;
  logic [STRAP_N*CODE_W-1:0]      strap_word;
  logic                           dev_rst;

  scl_dec_if dif ();

  scl_strap_decode u_dec (
    .dif (dif.dec)
  );

  // Straps arrive as level codes from the pin comparators.
  assign strap_in[IDX_ROLE] = role_rate_strap_i;
  assign strap_in[IDX_FMT]  = format_strap_i;
  assign strap_in[IDX_SLOT] = slot_pair_strap_i;
  assign strap_in[IDX_CLK]  = clock_order_strap_i;
  assign strap_in[IDX_FILT] = filter_strap_i;
  assign dif.strap          = st_r.strap;

  // Device reset: pin low or either supply monitor below threshold.
  assign dev_rst = !reset_n_i || avdd_low_i || dvdd_low_i;

  // Byte-lane mask and readback of the latched codes.
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W / 8; gi++) begin : g_lane
      assign sel_mask[8*gi +: 8] = {8{wb_sel_i[gi]}};
    end
    for (gi = 0; gi < STRAP_N; gi++) begin : g_strap
      assign strap_word[CODE_W*gi +: CODE_W] = st_r.strap[gi];
    end
  endgenerate

  // Next state: bus slave, reset sequencing and settings selection.
  always_comb begin
    logic     hit;
    scl_cfg_t swn;
    st_nxt = st_r;
    hit = wb_cyc_i && wb_stb_i && !st_r.ack;
    swn = scl_cfg_t'((st_r.sw & ~sel_mask[15:0]) | (wb_dat_i[15:0] & sel_mask[15:0]));
    st_nxt.ack = hit;
    st_nxt.rdat = '0;
    if (hit && !wb_we_i) begin
      case (wb_adr_i)
        ADR_STATUS: begin
          st_nxt.rdat[ST_IN_RESET]   = st_r.in_rst;
          st_nxt.rdat[ST_READY]      = st_r.ready;
          st_nxt.rdat[ST_SW_MODE]    = st_r.sw_mode;
          st_nxt.rdat[ST_CFG_ERR]    = st_r.err;
          st_nxt.rdat[ST_AUTODETECT] = st_r.autod;
        end
        ADR_ACTIVE: st_nxt.rdat = DATA_W'(st_r.act);
        ADR_SW_CFG: st_nxt.rdat = DATA_W'(st_r.sw);
        ADR_STRAPS: st_nxt.rdat = DATA_W'(strap_word);
        default:    st_nxt.rdat = '0;
      endcase
    end
    // The software register may be written outside the reset state, where it is held at SW_CFG_RST, but only steers the block in software mode.
    if (hit && wb_we_i && wb_adr_i == ADR_SW_CFG) begin
      st_nxt.sw = swn;
    end
    case (st_r.fsm)
      SCL_ST_RESET: begin
        st_nxt.in_rst = 1'b1;
        st_nxt.ready = 1'b0;
        st_nxt.sw = scl_cfg_t'(SW_CFG_RST);
        if (!dev_rst) begin
          st_nxt.strap = strap_in;
          st_nxt.fsm = SCL_ST_LATCH;
        end
      end
      SCL_ST_LATCH: begin
        // One cycle lets the decoder settle on the captured codes.
        st_nxt.sw_mode = dif.sw_mode;
        st_nxt.act = dif.sw_mode ? st_r.sw : dif.cfg;
        st_nxt.err = dif.sw_mode ? scl_cfg_err(st_r.sw) : dif.err;
        st_nxt.ready = 1'b1;
        st_nxt.in_rst = 1'b0;
        st_nxt.fsm = SCL_ST_RUN;
      end
      SCL_ST_RUN: begin
        // Hardware settings stay frozen; strap pins are not looked at again.
        if (st_r.sw_mode) begin
          st_nxt.act = st_r.sw;
          st_nxt.err = scl_cfg_err(st_r.sw);
        end
      end
      default: st_nxt.fsm = SCL_ST_RESET;
    endcase
    if (dev_rst) begin
      st_nxt.fsm = SCL_ST_RESET;
      st_nxt.in_rst = 1'b1;
      st_nxt.ready = 1'b0;
    end
    // Autodetect locks only to the listed rates and needs a master-clock reference.
    st_nxt.autod = st_nxt.ready && st_nxt.act.rate == SCL_RAUTO
                   && st_nxt.act.clk_ref != SCL_BCLK64;
    // Ratios are multiples of the family base rate, 48 kHz or 44.1 kHz.
    case (st_nxt.act.clk_ref)
      SCL_BCLK64:      st_nxt.ratio = RATIO_BCLK;
      SCL_MCLK256_PLL: st_nxt.ratio = RATIO_MCLK256;
      default:         st_nxt.ratio = RATIO_MCLK512;
    endcase
    st_nxt.gain_en = st_nxt.sw_mode && st_nxt.ready;
    st_nxt.i2c_sel = st_nxt.sw_mode ? st_nxt.strap[IDX_FILT] : '0;
  end

  // All state in one register; the clock enable freezes everything except the synchronous reset rst_i.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{fsm: SCL_ST_RESET, strap: '0, act: scl_cfg_t'(SW_CFG_RST),
                sw: scl_cfg_t'(SW_CFG_RST), in_rst: 1'b1, ratio: RATIO_MCLK256,
                default: '0};
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // Every output is a field of the state register.
  assign wb_dat_o          = st_r.rdat;
  assign wb_ack_o          = st_r.ack;
  assign cfg_o             = st_r.act;
  assign device_in_reset_o = st_r.in_rst;
  assign config_ready_o    = st_r.ready;
  assign sw_mode_o         = st_r.sw_mode;
  assign cfg_err_o         = st_r.err;
  assign autodetect_en_o   = st_r.autod;
  assign ref_ratio_o       = st_r.ratio;
  assign gain_pins_en_o    = st_r.gain_en;
  assign i2c_addr_sel_o    = st_r.i2c_sel;

  // Checks beside the logic; all in the one clock domain.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  reset_hold_a: assert property (ce_i && dev_rst |=> device_in_reset_o && !config_ready_o)
    else $error("device not held in reset");
  hw_frozen_a: assert property (st_r.fsm == SCL_ST_RUN && !sw_mode_o && !dev_rst |=> $stable(cfg_o))
    else $error("hardware settings changed while running");
  sw_decode_a: assert property (ce_i && !dev_rst && st_r.fsm == SCL_ST_LATCH
                                && st_r.strap[IDX_ROLE] == CODE_SW_MODE |=> sw_mode_o && gain_pins_en_o)
    else $error("software mode not decoded");
  role_decode_a: assert property (ce_i && !dev_rst && st_r.fsm == SCL_ST_LATCH
                                  && st_r.strap[IDX_ROLE] < CODE_PULLUP |=> !cfg_o.role_primary)
    else $error("pull-down did not give secondary role");
  autod_clock_a: assert property (autodetect_en_o |-> cfg_o.clk_ref != SCL_BCLK64 && cfg_o.rate == SCL_RAUTO)
    else $error("autodetect with bit clock reference");
  fmt_decode_a: assert property (ce_i && !dev_rst && st_r.fsm == SCL_ST_LATCH && !dif.sw_mode
                                 && st_r.strap[IDX_FMT] == 3'h5
                                 |=> cfg_o.fmt == SCL_TDM_MAX && cfg_o.launch_full)
    else $error("full-cycle maximum-slot TDM not decoded");
  slot_pair_a: assert property (ce_i && !dev_rst && st_r.fsm == SCL_ST_LATCH && !dif.sw_mode
                                && dif.cfg.fmt == SCL_TDM_MAX
                                |=> cfg_o.slot_pair == $past(st_r.strap[IDX_SLOT]))
    else $error("slot pair not taken from third strap");
  clk_order_a: assert property (ce_i && !dev_rst && st_r.fsm == SCL_ST_LATCH && !dif.sw_mode
                                |=> cfg_o.order_rev == ($past(st_r.strap[IDX_CLK]) < CODE_PULLUP))
    else $error("channel order does not follow fourth strap");
  filter_a: assert property (ce_i && !dev_rst && st_r.fsm == SCL_ST_LATCH && !dif.sw_mode
                             |=> cfg_o.hpf_bypass == $past(st_r.strap[IDX_FILT][2]))
    else $error("high-pass choice does not follow fifth strap");
  latch_sample_a: assert property (ce_i && !dev_rst && st_r.fsm == SCL_ST_RESET
                                   |=> st_r.fsm == SCL_ST_LATCH && st_r.strap == $past(strap_in))
    else $error("straps not captured at reset release");
  sw_follow_a: assert property (ce_i && !dev_rst && sw_mode_o && st_r.fsm == SCL_ST_RUN
                                |=> cfg_o == $past(st_r.sw))
    else $error("software settings not applied");
  cfg_err_a: assert property (config_ready_o |-> cfg_err_o == scl_cfg_err(cfg_o))
    else $error("error flag disagrees with active settings");
  wb_ack_a: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 (!ce_i || !wb_ack_o))
    else $error("bus answer not a single cycle");

  hw_run_c: cover property (config_ready_o && !sw_mode_o && !cfg_err_o);
  sw_run_c: cover property (config_ready_o && sw_mode_o);
  err_c: cover property (config_ready_o && cfg_err_o);
  relatch_c: cover property (config_ready_o ##1 device_in_reset_o [*2] ##[1:8] config_ready_o);

endmodule
`default_nettype wire

// ### scl_board_model.sv
/*
  Model of the board straps and the system reset source facing the strap latch.
  Assumes the bench asks for a reset source, a strap set and strap drift by ports.
*/
`timescale 1ns/1ps
`default_nettype none
module scl_board_model (
  input  wire logic        clk_i,
  input  wire logic [14:0] want_i,
  input  wire logic [1:0]  src_i,
  input  wire logic        hold_i,
  input  wire logic        drift_i,
  output var  logic        reset_n_o  = 1'b0,
  output var  logic        avdd_low_o = 1'b0,
  output var  logic        dvdd_low_o = 1'b0,
  output var  logic [14:0] straps_o   = 15'h0000
);
  // A board fits new resistors while hold_i is high, under reset when src_i is 0..2 and with no reset at 3; drift in run is a commanded fault.
  always @(posedge clk_i) begin
    reset_n_o  <= !(hold_i && src_i == 2'h0);
    avdd_low_o <= hold_i && src_i == 2'h1;
    dvdd_low_o <= hold_i && src_i == 2'h2;
    if (hold_i || drift_i) begin
      straps_o <= want_i;
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
/*
  Self-checking bench of the strap latch: boots it from many strap sets and
  checks decodes, software mode and the register bus. Assumes one 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import scl_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [3:0]  wb_sel = 4'h0;
  logic        wb_we = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0;
  logic [14:0] want = 15'h0000, straps;
  logic [1:0]  src = 2'h0;
  logic        hold = 1'b1, drift = 1'b0;
  logic        reset_n, avdd_low, dvdd_low, ack, in_rst, ready, swm, err, autod, gain;
  logic [31:0] rdat, q;
  scl_cfg_t    cfg;
  logic [9:0]  ratio;
  logic [2:0]  i2c;
  int          mismatches = 0;
  int          compares = 0;
  logic [1:0]  rate_tab [8] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h2, 2'h1, 2'h0, 2'h0};
  logic [2:0]  fmt_tab [8] = '{3'h0, 3'h1, 3'h4, 3'h4, 3'h4, 3'h3, 3'h3, 3'h2};

  scl_board_model board (.clk_i(clk_i), .want_i(want), .src_i(src), .hold_i(hold), .drift_i(drift),
    .reset_n_o(reset_n), .avdd_low_o(avdd_low), .dvdd_low_o(dvdd_low), .straps_o(straps));

  scl_strap_latch dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .reset_n_i(reset_n),
    .avdd_low_i(avdd_low), .dvdd_low_i(dvdd_low), .role_rate_strap_i(straps[2:0]),
    .format_strap_i(straps[5:3]), .slot_pair_strap_i(straps[8:6]), .clock_order_strap_i(straps[11:9]),
    .filter_strap_i(straps[14:12]), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel),
    .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cfg_o(cfg), .device_in_reset_o(in_rst), .config_ready_o(ready), .sw_mode_o(swm),
    .cfg_err_o(err), .autodetect_en_o(autod), .ref_ratio_o(ratio), .gain_pins_en_o(gain),
    .i2c_addr_sel_o(i2c));

  // The clock toggles every 12.5 ns, half of its 25 ns period.
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic conclude;
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The request stands until the rising edge that samples ack high; read data is taken at that edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    wb_sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk({31'h0, ack}, 32'h1);
    r = rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  // Holds a reset source with new straps, then releases it and lets the latch settle.
  task automatic boot(input logic [14:0] v, input logic [1:0] sc);
    @(posedge clk_i);
    want <= v;
    src <= sc;
    hold <= 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk({ready, in_rst}, 2'b01);
    @(posedge clk_i);
    hold <= 1'b0;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic hw_check(input logic [2:0] r, input logic [2:0] f, input logic [2:0] s,
                          input logic [2:0] c, input logic [2:0] l);
    scl_cfg_t   e;
    logic [2:0] m;
    logic       bc;
    logic [9:0] rt;
    e = '0;
    e.role_primary = r >= 3'h4;
    e.rate = scl_rate_t'(rate_tab[r]);
    e.fmt = scl_fmt_t'(fmt_tab[f]);
    e.launch_full = f == 3'h5;
    e.slot_pair = (f == 3'h5 || f == 3'h6) ? s : 3'h0;
    m = (c >= 3'h4) ? 3'h7 - c : c;
    e.clk_ref = scl_clk_t'(m[1:0]);
    e.order_rev = c < 3'h4;
    m = (l >= 3'h4) ? 3'h7 - l : l;
    e.hpf_bypass = l >= 3'h4;
    e.linear = m[1];
    e.fast = m[0];
    bc = e.clk_ref == SCL_BCLK64;
    rt = bc ? RATIO_BCLK : (e.clk_ref == SCL_MCLK256_PLL) ? RATIO_MCLK256 : RATIO_MCLK512;
    chk(32'(cfg), 32'(e));
    chk({31'h0, err}, {31'h0, (bc && (e.role_primary || r == 3'h0 || e.fmt == SCL_TDM_MAX))
        || e.fmt == SCL_FMT_UNDEF});
    chk({22'h0, ratio}, {22'h0, rt});
    chk({31'h0, autod}, {31'h0, r == 3'h0 && !bc});
    chk({gain, swm, i2c, ready, in_rst}, 7'b0000010);
  endtask

  // A hang past the expected few hundred cycles ends the run as a failure.
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    conclude();
  end

  // Every strap swept through all codes, then software mode, slot pairs and drift.
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      boot({5{3'(k)}}, 2'(k % 3));
      if (k < 7) begin
        hw_check(3'(k), 3'(k), 3'(k), 3'(k), 3'(k));
      end
    end
    chk({gain, swm, i2c}, 5'b11111);
    chk(32'(cfg), 32'(SW_CFG_RST));
    wb(1'b1, ADR_SW_CFG, 32'h0000ABCD, 4'h1, q);
    wb(1'b0, ADR_SW_CFG, 32'h0, 4'hF, q);
    chk(q, 32'h000000CD);
    chk(32'(cfg), 32'h000000CD);
    wb(1'b1, ADR_STATUS, 32'hFFFFFFFF, 4'hF, q);
    wb(1'b0, ADR_STATUS, 32'h0, 4'hF, q);
    chk(q, 32'h00000006);
    wb(1'b0, 8'h10, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    wb(1'b0, ADR_STRAPS, 32'h0, 4'hF, q);
    chk(q, 32'h00007FFF);
    // Slot pairs assume a 16-slot frame on the board side.
    for (int k = 0; k < 8; k++) begin
      boot({3'(k), 3'h5, 3'(k), 3'h6, 3'h0}, 2'h0);
      hw_check(3'h0, 3'h6, 3'(k), 3'h5, 3'(k));
    end
    @(posedge clk_i);
    want <= 15'h1234;
    drift <= 1'b1;
    wb(1'b1, ADR_SW_CFG, 32'h00005555, 4'hF, q);
    drift <= 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    hw_check(3'h0, 3'h6, 3'h7, 3'h5, 3'h7);
    conclude();
  end
endmodule
`default_nettype wire
